//--- rtl/timer3_counter.v
// 16-bit timer/counter with APB registers, buffered access and overflow interrupt
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "timer3_regs.vh"
module timer3_counter (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Clock sources
  input wire instrTick,
  input wire extClockPin,
  input wire lpOscClock,
  input wire lpOscEnable,
  // Port pins of the shared oscillator
  input wire [1:0] portPinIn,
  input wire [1:0] portDirection,
  output wire [1:0] portPinOe,
  // Compare units
  input wire [4:0] compareEvent,
  input wire [19:0] compareModeField,
  output wire [4:0] useTimer34,
  // Interrupt
  output wire irq
);
  reg [7:0] control_reg;
  reg [15:0] count_reg;
  reg [7:0] buffer_reg;
  reg flag_reg;
  reg enable_reg;
  reg [7:0] rdata_next;
  reg [15:0] count_next;
  wire wrEn;
  wire rdEn;
  wire wideMode;
  wire clkSel;
  wire runOn;
  wire extRise;
  wire rawTick;
  wire preTick;
  wire lowWrite;
  wire highWrite;
  wire lowRead;
  wire statusRead;
  wire trigger;
  wire overflow;
  wire cntWrite;
  wire [7:0] wbyte;
  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign wbyte = pwdata[7:0];
  assign lowWrite = wrEn && (paddr == `ADDR_LOW);
  assign highWrite = wrEn && (paddr == `ADDR_HIGH);
  assign lowRead = rdEn && (paddr == `ADDR_LOW);
  assign statusRead = rdEn && (paddr == `ADDR_STATUS);
  // only writes that reach the count mask trigger and wrap
  assign cntWrite = lowWrite || (highWrite && !wideMode);
  assign wideMode = control_reg[`BIT_WIDE];
  assign clkSel = control_reg[`BIT_CLKSEL];
  assign runOn = control_reg[`BIT_RUN];
  ////////////////////////////////////////////////////////////////////////
  // Routing to compare units
  function [4:0] route_map;
    input [1:0] code;
    begin
      case (code)
        2'b11: route_map = 5'h1F;
        2'b10: route_map = 5'h1C;
        2'b01: route_map = 5'h1E;
        default: route_map = 5'h00;
      endcase
    end
  endfunction
  assign useTimer34 = route_map({control_reg[`BIT_ROUTE_HI], control_reg[`BIT_ROUTE_LO]});
  // trigger from a unit routed here in mode 1011
  genvar u;
  wire [4:0] trigHit;
  generate
    for (u = 0; u < 5; u = u + 1) begin : trig_g
      assign trigHit[u] = compareEvent[u] && useTimer34[u] &&
        (compareModeField[4*u+3:4*u] == `COMPARE_RESET_MODE);
    end
  endgenerate
  // Async counter mode ignores the reset, as on the original part
  assign trigger = |trigHit && !(clkSel && control_reg[`BIT_NOSYNC]);
  ////////////////////////////////////////////////////////////////////////
  // Clock source and prescaler
  // oscillator pins forced to inputs
  assign portPinOe = lpOscEnable ? 2'b00 : ~portDirection;
  // sync select inside the edge detector
  ext_edge_detect edge_u (
    .clk(clk),
    .reset_n(reset_n),
    .noSync(control_reg[`BIT_NOSYNC]),
    .armClear(!clkSel),
    .extLevel(lpOscEnable ? lpOscClock : extClockPin),
    .risePulse(extRise)
  );
  // source select: instruction tick or external edge
  assign rawTick = runOn && (clkSel ? extRise : instrTick);
  prescaler pre_u (
    .clk(clk),
    .reset_n(reset_n),
    .sel(control_reg[`BIT_PS_HI:`BIT_PS_LO]),
    .clear(lowWrite),
    .tickIn(rawTick),
    .tickOut(preTick)
  );
  ////////////////////////////////////////////////////////////////////////
  // Counter
  // wrap detect, trigger excluded
  // A buffered high write leaves the count alone, so it must not hide a wrap
  assign overflow = preTick && (count_reg == `COUNT_MAX) && !cntWrite && !trigger;
  always @* begin
    count_next = count_reg;
    if (preTick)
      count_next = count_reg + 16'h0001;
    if (trigger && !cntWrite)
      count_next = `COUNT_ZERO;
    if (lowWrite) begin
      count_next[7:0] = wbyte;
      if (wideMode)
        count_next[15:8] = buffer_reg;
    end
    if (highWrite && !wideMode)
      count_next[15:8] = wbyte;
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= `COUNT_ZERO;
      buffer_reg <= 8'h00;
      control_reg <= `CTRL_RESET;
      flag_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      // high address hits buffer in wide mode
      if (highWrite && wideMode)
        buffer_reg <= wbyte;
      else if (lowRead && wideMode)
        buffer_reg <= count_reg[15:8];
      if (wrEn && paddr == `ADDR_CTRL)
        control_reg <= wbyte;
      if (wrEn && paddr == `ADDR_MASK)
        enable_reg <= wbyte[0];
      // Set wins over read clear
      if (overflow)
        flag_reg <= 1'b1;
      else if (statusRead)
        flag_reg <= 1'b0;
    end
  end
  assign irq = flag_reg && enable_reg;
  ////////////////////////////////////////////////////////////////////////
  // Read data
  always @* begin
    case (paddr)
      `ADDR_LOW: rdata_next = count_reg[7:0];
      `ADDR_HIGH: rdata_next = wideMode ? buffer_reg : count_reg[15:8];
      `ADDR_CTRL: rdata_next = control_reg;
      `ADDR_STATUS: rdata_next = {7'h00, flag_reg};
      `ADDR_MASK: rdata_next = {7'h00, enable_reg};
      `ADDR_PINS: rdata_next = {6'h00, lpOscEnable ? 2'b00 : portPinIn};
      `ADDR_ROUTE: rdata_next = {3'h0, useTimer34};
      default: rdata_next = 8'h00;
    endcase
  end
  // Combinational read, captured by the master at the access edge
  always @* begin
    prdata = {24'h000000, rdata_next};
  end
endmodule // timer3_counter

//--- rtl/timer3_regs.vh
// Register map, field positions and reset values of the 16-bit timer/counter
`ifndef TIMER3_REGS_VH
`define TIMER3_REGS_VH
`define ADDR_LOW 12'h000
`define ADDR_HIGH 12'h004
`define ADDR_CTRL 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_MASK 12'h010
`define ADDR_PINS 12'h014
`define ADDR_ROUTE 12'h018
`define CTRL_RESET 8'h00
`define BIT_WIDE 7
`define BIT_ROUTE_HI 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_ROUTE_LO 3
`define BIT_NOSYNC 2
`define BIT_CLKSEL 1
`define BIT_RUN 0
`define COMPARE_RESET_MODE 4'hB
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`endif

//--- rtl/ext_edge_detect.v
// External clock path: optional synchroniser and rising-edge detector
`timescale 1ns/1ps
module ext_edge_detect (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control
  input wire noSync,
  input wire armClear,
  // External level
  input wire extLevel,
  // Edge out
  output wire risePulse
);
  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  reg armed_reg;
  wire level;
  // Unsynchronised path trades metastability safety for latency
  assign level = noSync ? extLevel : sync2_reg;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      sync1_reg <= extLevel;
      sync2_reg <= sync1_reg;
      prev_reg <= level;
      if (armClear)
        armed_reg <= 1'b0;
      else if (prev_reg && !level)
        armed_reg <= 1'b1;
    end
  end
  assign risePulse = armed_reg && !prev_reg && level;
endmodule // ext_edge_detect

//--- rtl/prescaler.v
// Prescaler 1:1, 1:2, 1:4, 1:8 ahead of the counter
`timescale 1ns/1ps
module prescaler (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Control
  input wire [1:0] sel,
  input wire clear,
  input wire tickIn,
  // Output
  output wire tickOut
);
  reg [2:0] count_reg;
  wire [2:0] limit;
  assign limit = (sel == 2'b11) ? 3'h7 : (sel == 2'b10) ? 3'h3 : (sel == 2'b01) ? 3'h1 : 3'h0;
  assign tickOut = tickIn && (count_reg >= limit);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      count_reg <= 3'h0;
    else if (clear)
      count_reg <= 3'h0;
    else if (tickIn)
      count_reg <= tickOut ? 3'h0 : count_reg + 3'h1;
  end
endmodule // prescaler

//--- bench/timer3_counter_checker.sv
// Port checker for the 16-bit timer/counter
`timescale 1ns/1ps
`include "timer3_regs.vh"
module timer3_counter_checker (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // Pins, routing, interrupt
  input wire lpOscEnable,
  input wire [1:0] portPinOe,
  input wire [4:0] useTimer34,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rd = psel && penable && !pwrite;
  wire wr = psel && penable && pwrite;
  chk_upper_zero: assert property (rd |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_osc_pins: assert property (lpOscEnable |-> portPinOe == 2'h0)
    else $error("pin driven with oscillator on");
  chk_pins_zero: assert property (rd && paddr == `ADDR_PINS && lpOscEnable |-> !prdata[1:0])
    else $error("pin read not zero");
  chk_route_write: assert property (wr && paddr == `ADDR_CTRL |=> useTimer34 ==
    ($past(pwdata[6]) ? ($past(pwdata[3]) ? 5'h1F : 5'h1C) : ($past(pwdata[3]) ? 5'h1E : 5'h00)))
    else $error("routing wrong");
  chk_route_read: assert property (rd && paddr == `ADDR_ROUTE |-> prdata[4:0] == useTimer34)
    else $error("routing readback wrong");
  chk_irq_status: assert property (rd && paddr == `ADDR_STATUS && irq |-> prdata[0])
    else $error("irq without flag");
  chk_status_clear: assert property (rd && paddr == `ADDR_STATUS |=> !irq)
    else $error("flag not cleared by read");
  chk_mask_off: assert property (wr && paddr == `ADDR_MASK && !pwdata[0] |=> !irq)
    else $error("masked irq high");
endmodule // timer3_counter_checker
bind timer3_counter timer3_counter_checker chk_u (.clk, .reset_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .lpOscEnable, .portPinOe, .useTimer34, .irq);

//--- bench/far_side_model.sv
// Behavioural compare units and external clock source
`timescale 1ns/1ps
module far_side_model (
  // Clock and bench controls
  input wire clk,
  input wire trig,
  input wire extRun,
  // Toward the timer
  output logic [4:0] compareEvent = 5'h00,
  output wire [19:0] compareModeField,
  output logic extClockPin = 1'b0
);
  logic [1:0] phase = 2'h0;
  assign compareModeField = {5{4'hB}};
  // Pin holds its last level outside a burst
  always @(posedge clk) begin
    compareEvent <= {5{trig}};
    phase <= extRun ? phase + 2'h1 : 2'h0;
    if (extRun && phase == 2'h3) extClockPin <= !extClockPin;
  end
endmodule // far_side_model

//--- bench/timer3_counter_tb.sv
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/1ps
`include "timer3_regs.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module timer3_counter_tb;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, instrTick = 0;
  logic lpOscEnable = 0, trig = 0, extRun = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, e;
  logic [1:0] portPinIn = 2'h3;
  logic [1:0] portDirection = 2'h0;
  wire pready, pslverr, irq, extClockPin;
  wire [31:0] prdata;
  wire [1:0] portPinOe;
  wire [4:0] useTimer34, compareEvent;
  wire [19:0] compareModeField;
  logic [31:0] expQ[$];
  logic [4:0] rt[4] = '{5'h00, 5'h1E, 5'h1C, 5'h1F};
  logic [7:0] rv;
  int error_cnt = 0, tests_run = 0, cycles = 0, seed = 59977;
  always #5 clk = ~clk;
  timer3_counter dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .instrTick, .extClockPin, .lpOscClock(1'b0), .lpOscEnable, .portPinIn,
    .portDirection, .portPinOe, .compareEvent, .compareModeField, .useTimer34, .irq);
  far_side_model far_u (.clk, .trig, .extRun, .compareEvent, .compareModeField, .extClockPin);
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hold request until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    expQ.push_back(x);
    apb(0, a, 0);
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge clk) instrTick <= 1;
      @(posedge clk) instrTick <= 0;
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      error_cnt++;
      stop_test();
    end
    if (psel && penable && pready && !pwrite) begin
      e = expQ.pop_front();
      `CHK("prdata", e, prdata)
      `CHK("pslverr", 1'b0, pslverr)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1;
    rd(`ADDR_CTRL, 0);
    rv = 8'($random(seed));
    wr(`ADDR_HIGH, 32'(rv));
    rd(`ADDR_HIGH, 32'(rv));
    wr(`ADDR_CTRL, 32'h80);
    wr(`ADDR_HIGH, 32'h12);
    rd(`ADDR_HIGH, 32'h12);
    rd(`ADDR_LOW, 0);
    rd(`ADDR_HIGH, 32'(rv));
    wr(`ADDR_HIGH, 32'h12);
    wr(`ADDR_LOW, 32'h34);
    wr(`ADDR_CTRL, 0);
    rd(`ADDR_HIGH, 32'h12);
    wr(`ADDR_MASK, 1);
    for (int p = 0; p < 4; p++) begin
      wr(`ADDR_CTRL, 32'h81 | (p << 4));
      wr(`ADDR_HIGH, 32'hFF);
      wr(`ADDR_LOW, 32'hFF);
      ticks((2 << p) - 1);
      repeat (2) @(posedge clk);
      `CHK("irq", 1'b1, irq)
      rd(`ADDR_STATUS, 1);
      rd(`ADDR_LOW, 0);
    end
    wr(`ADDR_CTRL, 32'h80);
    ticks(3);
    rd(`ADDR_LOW, 0);
    wr(`ADDR_CTRL, 32'h11);
    wr(`ADDR_LOW, 0);
    ticks(1);
    wr(`ADDR_HIGH, 0);
    ticks(1);
    rd(`ADDR_LOW, 1);
    for (int r = 0; r < 4; r++) begin
      wr(`ADDR_CTRL, 32'({r[1], 2'b00, r[0], 3'b000}));
      rd(`ADDR_ROUTE, 32'(rt[r]));
    end
    wr(`ADDR_CTRL, 32'hC9);
    wr(`ADDR_HIGH, 32'h55);
    wr(`ADDR_LOW, 32'h66);
    @(posedge clk) trig <= 1;
    @(posedge clk) trig <= 0;
    repeat (3) @(posedge clk);
    rd(`ADDR_LOW, 0);
    rd(`ADDR_STATUS, 0);
    // Trigger lands on the access edge of the low write
    fork
      wr(`ADDR_LOW, 32'h77);
      begin
        @(posedge clk) trig <= 1;
        @(posedge clk) trig <= 0;
      end
    join
    rd(`ADDR_LOW, 32'h77);
    wr(`ADDR_CTRL, 32'h03);
    @(posedge clk) extRun <= 1;
    repeat (32) @(posedge clk);
    extRun <= 0;
    repeat (6) @(posedge clk);
    rd(`ADDR_LOW, 32'h7A);
    // Unsynchronised path counts the rise before the read, synced one after
    wr(`ADDR_CTRL, 32'h07);
    @(posedge clk) extRun <= 1;
    repeat (4) @(posedge clk);
    extRun <= 0;
    rd(`ADDR_LOW, 32'h7B);
    `CHK("portPinOe", 2'h3, portPinOe)
    lpOscEnable <= 1;
    rd(`ADDR_PINS, 0);
    `CHK("portPinOe", 2'h0, portPinOe)
    wr(`ADDR_MASK, 0);
    reset_n <= 0;
    @(posedge clk) reset_n <= 1;
    rd(`ADDR_CTRL, 0);
    rd(`ADDR_LOW, 0);
    stop_test();
  end
endmodule // timer3_counter_tb
